// ===== core/dso_channel.sv
`timescale 1ns/10ps
`default_nettype none
// one fixed output channel carrying a reprogrammable status flag
module dso_channel (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dso_pkg::dso_sig_t sel_in,
    input wire dso_pkg::dso_flags_t flags_in,
    output logic level_out
);
    import dso_pkg::*;

    logic level_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_q <= 1'b0;
        end else begin
            level_q <= pick_flag(sel_in, flags_in);
        end
    end

    assign level_out = level_q;
endmodule
`default_nettype wire

// ===== core/dso_pkg.sv
package dso_pkg;
    localparam int unsigned SPEED_W = 16;
    localparam int unsigned POS_W = 32;
    localparam int unsigned THR_W = 16;
    localparam int unsigned FLAG_W = 5;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned MODE_W = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // byte addresses of the register words
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ZERO_THR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TARGET_SPD = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_POS_WIN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DO_MAP = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h1c;
    // field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_FACTORY_BIT = 8;
    localparam int unsigned FLAGS_DO_LSB = 8;
    // reset values
    localparam logic [THR_W-1:0] ZERO_THR_DEF = 16'h000a;
    localparam logic [THR_W-1:0] POS_WIN_DEF = 16'h0063;
    localparam logic [FLAG_W-1:0] IRQ_MASK_DEF = 5'h00;

    typedef enum logic [MODE_W-1:0] {
        external_pulse_position_mode,
        internal_position_mode,
        speed_mode,
        torque_mode,
        ext_pulse_speed_mode,
        ext_pulse_torque_mode,
        int_position_speed_mode,
        int_position_torque_mode,
        speed_torque_mode
    } dso_mode_t;
    localparam logic [MODE_W-1:0] MODE_COUNT = 4'h9;
    localparam dso_mode_t MODE_DEF = external_pulse_position_mode;

    typedef enum logic [SEL_W-1:0] {
        sig_none,
        sig_drive_ready,
        sig_power_on,
        sig_zero_speed,
        sig_target_speed,
        sig_in_position
    } dso_sig_t;

    typedef struct packed {
        logic drive_ready;
        logic power_on;
        logic zero_speed;
        logic target_speed;
        logic in_position;
    } dso_flags_t;

    typedef struct packed {
        logic control_power;
        logic run_capable;
        logic alarm_pending;
        logic signed [SPEED_W-1:0] speed_rpm;
        logic signed [POS_W-1:0] pos_error;
        logic signed [POS_W-1:0] motor_pos;
        logic signed [POS_W-1:0] target_pos;
    } dso_drive_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } dso_apb_req_t;

    // picks the status flag that a channel carries
    function automatic logic pick_flag(input dso_sig_t sel, input dso_flags_t f);
        logic r;
        r = 1'b0;
        unique case (sel)
            sig_none: r = 1'b0;
            sig_drive_ready: r = f.drive_ready;
            sig_power_on: r = f.power_on;
            sig_zero_speed: r = f.zero_speed;
            sig_target_speed: r = f.target_speed;
            sig_in_position: r = f.in_position;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic is_ext_pulse(input dso_mode_t m);
        return (m == external_pulse_position_mode) || (m == ext_pulse_speed_mode) ||
            (m == ext_pulse_torque_mode);
    endfunction

    function automatic logic is_int_position(input dso_mode_t m);
        return (m == internal_position_mode) || (m == int_position_speed_mode) ||
            (m == int_position_torque_mode);
    endfunction

    // factory assignment of a channel for a control mode
    function automatic dso_sig_t default_sig(input dso_mode_t m, input int unsigned ch);
        dso_sig_t s;
        s = sig_none;
        if (ch == 0) begin
            s = sig_drive_ready;
        end else if (ch == 1) begin
            s = sig_zero_speed;
        end else if (ch == 2) begin
            s = (is_ext_pulse(m) || is_int_position(m)) ? sig_none : sig_target_speed;
        end else if (ch == 3) begin
            s = (is_ext_pulse(m) || is_int_position(m)) ? sig_in_position : sig_none;
        end
        return s;
    endfunction
endpackage

// ===== core/dso_top.sv
// Notes on behaviour
// - drive ready only when able to run and no alarm pending
// - power-on flag follows control power, regardless of alarms
// - zero speed while speed magnitude is at or below its threshold
// - zero-speed threshold resets to 10 rpm; flag clears only above it
// - target speed set once speed reaches setting, cleared below it
// - target speed never asserted in the two pure position modes
// - external pulse modes: in position while error within window
// - channels fixed; signal per channel reprogrammable and swappable
// - factory reset loads per-mode default channel assignments
// - internal position modes: in position within plus/minus window of target
`timescale 1ns/10ps
`default_nettype none
module dso_top #(
    parameter int unsigned CHANNELS = 5,
    parameter logic [15:0] TARGET_SPD_DEF = 16'h0064
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dso_pkg::dso_apb_req_t apb_req_in,
    output logic pready_out,
    output logic [dso_pkg::DATA_W-1:0] prdata_out,
    output logic pslverr_out,
    input wire dso_pkg::dso_drive_t drive_in,
    output logic drive_ready_out,
    output logic control_power_on_out,
    output logic zero_speed_out,
    output logic target_speed_out,
    output logic in_position_out,
    output logic [CHANNELS-1:0] do_channel_out,
    output logic irq_out
);
    import dso_pkg::*;

    localparam int unsigned MAP_W = CHANNELS * SEL_W;

    if (CHANNELS < 1 || MAP_W > DATA_W || FLAGS_DO_LSB + CHANNELS > DATA_W) begin : g_chk
        $error("dso_top: CHANNELS out of range");
    end

    // register state
    dso_mode_t mode_q;
    logic [THR_W-1:0] zero_speed_threshold_q;
    logic [THR_W-1:0] target_speed_setting_q;
    logic [THR_W-1:0] position_window_q;
    dso_sig_t map_q [CHANNELS];
    logic [FLAG_W-1:0] irq_status_q;
    logic [FLAG_W-1:0] irq_mask_q;
    logic irq_q;
    dso_flags_t flags_q;
    dso_flags_t flags_d;
    logic [DATA_W-1:0] prdata_q;
    logic pslverr_q;

    // bus decode
    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic factory_load;
    logic [DATA_W-1:0] rd_data;
    logic [MAP_W-1:0] map_flat;
    logic [CHANNELS-1:0] do_level;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_ZERO_THR) || (a == OFF_TARGET_SPD) ||
            (a == OFF_POS_WIN) || (a == OFF_DO_MAP) || (a == OFF_FLAGS) ||
            (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK);
    endfunction

    function automatic logic wr_hit(input dso_apb_req_t r, input logic [ADDR_W-1:0] a);
        return r.psel && r.penable && r.pwrite && (r.paddr == a);
    endfunction

    function automatic logic [SPEED_W-1:0] speed_mag(input logic signed [SPEED_W-1:0] v);
        return v[SPEED_W-1] ? SPEED_W'(-v) : v;
    endfunction

    function automatic logic [POS_W:0] pos_mag(input logic signed [POS_W:0] v);
        return v[POS_W] ? (POS_W+1)'(-v) : v;
    endfunction

    assign setup_phase = apb_req_in.psel && !apb_req_in.penable;
    assign access_phase = apb_req_in.psel && apb_req_in.penable;
    assign wr_en = access_phase && apb_req_in.pwrite;
    assign factory_load = wr_hit(apb_req_in, OFF_CTRL) &&
        apb_req_in.pwdata[CTRL_FACTORY_BIT];

    // status computation
    logic [SPEED_W-1:0] spd_abs;
    logic [POS_W:0] err_abs;
    logic [POS_W:0] dist_abs;
    logic signed [POS_W:0] dist_raw;

    always_comb begin
        spd_abs = speed_mag(drive_in.speed_rpm);
        err_abs = pos_mag({drive_in.pos_error[POS_W-1], drive_in.pos_error});
        dist_raw = {drive_in.target_pos[POS_W-1], drive_in.target_pos} -
            {drive_in.motor_pos[POS_W-1], drive_in.motor_pos};
        dist_abs = pos_mag(dist_raw);
    end

    always_comb begin
        flags_d.drive_ready = drive_in.control_power && drive_in.run_capable &&
            !drive_in.alarm_pending;
        flags_d.power_on = drive_in.control_power;
        flags_d.zero_speed = (spd_abs <= zero_speed_threshold_q);
        flags_d.target_speed = (spd_abs >= target_speed_setting_q) &&
            (mode_q != external_pulse_position_mode) &&
            (mode_q != internal_position_mode);
        flags_d.in_position = 1'b0;
        if (is_ext_pulse(mode_q)) begin
            flags_d.in_position = (err_abs <= (POS_W+1)'(position_window_q));
        end else if (is_int_position(mode_q)) begin
            flags_d.in_position = (dist_abs <= (POS_W+1)'(position_window_q));
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign drive_ready_out = flags_q.drive_ready;
    assign control_power_on_out = flags_q.power_on;
    assign zero_speed_out = flags_q.zero_speed;
    assign target_speed_out = flags_q.target_speed;
    assign in_position_out = flags_q.in_position;

    // control mode; codes beyond the list are ignored
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= MODE_DEF;
        end else if (wr_hit(apb_req_in, OFF_CTRL) &&
                apb_req_in.pwdata[CTRL_MODE_LSB +: MODE_W] < MODE_COUNT) begin
            mode_q <= dso_mode_t'(apb_req_in.pwdata[CTRL_MODE_LSB +: MODE_W]);
        end
    end

    // thresholds; a factory load restores their defaults
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zero_speed_threshold_q <= ZERO_THR_DEF;
            target_speed_setting_q <= TARGET_SPD_DEF;
            position_window_q <= POS_WIN_DEF;
        end else if (factory_load) begin
            zero_speed_threshold_q <= ZERO_THR_DEF;
            target_speed_setting_q <= TARGET_SPD_DEF;
            position_window_q <= POS_WIN_DEF;
        end else begin
            if (wr_hit(apb_req_in, OFF_ZERO_THR)) begin
                zero_speed_threshold_q <= apb_req_in.pwdata[THR_W-1:0];
            end
            if (wr_hit(apb_req_in, OFF_TARGET_SPD)) begin
                target_speed_setting_q <= apb_req_in.pwdata[THR_W-1:0];
            end
            if (wr_hit(apb_req_in, OFF_POS_WIN)) begin
                position_window_q <= apb_req_in.pwdata[THR_W-1:0];
            end
        end
    end

    // channel assignment: one select field per fixed channel
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic [SEL_W-1:0] wr_sel;
        logic wr_legal;

        assign wr_sel = apb_req_in.pwdata[i*SEL_W +: SEL_W];
        assign wr_legal = wr_sel <= SEL_W'(sig_in_position);

        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                map_q[i] <= default_sig(MODE_DEF, i);
            end else if (factory_load) begin
                // defaults follow the mode written along with the load, or the held mode_q if that code is illegal
                if (apb_req_in.pwdata[CTRL_MODE_LSB +: MODE_W] < MODE_COUNT) begin
                    map_q[i] <= default_sig(
                        dso_mode_t'(apb_req_in.pwdata[CTRL_MODE_LSB +: MODE_W]), i);
                end else begin
                    map_q[i] <= default_sig(mode_q, i);
                end
            end else if (wr_hit(apb_req_in, OFF_DO_MAP) && wr_legal) begin
                map_q[i] <= dso_sig_t'(wr_sel);
            end
        end

        assign map_flat[i*SEL_W +: SEL_W] = map_q[i];

        dso_channel u_channel (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .sel_in(map_q[i]),
            .flags_in(flags_d),
            .level_out(do_level[i])
        );
    end

    assign do_channel_out = do_level;

    // sticky events on each rising status flag; set beats clear
    logic [FLAG_W-1:0] rise;
    logic [FLAG_W-1:0] clr_bits;

    assign rise = flags_d & ~flags_q;
    assign clr_bits = wr_hit(apb_req_in, OFF_IRQ_STATUS) ?
        apb_req_in.pwdata[FLAG_W-1:0] : '0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~clr_bits) | rise;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_mask_q <= IRQ_MASK_DEF;
        end else if (wr_hit(apb_req_in, OFF_IRQ_MASK)) begin
            irq_mask_q <= apb_req_in.pwdata[FLAG_W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    assign irq_out = irq_q;

    // read mux
    always_comb begin
        rd_data = '0;
        unique case (apb_req_in.paddr)
            OFF_CTRL: begin
                rd_data[CTRL_MODE_LSB +: MODE_W] = mode_q;
            end
            OFF_ZERO_THR: begin
                rd_data[THR_W-1:0] = zero_speed_threshold_q;
            end
            OFF_TARGET_SPD: begin
                rd_data[THR_W-1:0] = target_speed_setting_q;
            end
            OFF_POS_WIN: begin
                rd_data[THR_W-1:0] = position_window_q;
            end
            OFF_DO_MAP: begin
                rd_data[MAP_W-1:0] = map_flat;
            end
            OFF_FLAGS: begin
                rd_data[FLAG_W-1:0] = flags_q;
                rd_data[FLAGS_DO_LSB +: CHANNELS] = do_level;
            end
            OFF_IRQ_STATUS: begin
                rd_data[FLAG_W-1:0] = irq_status_q;
            end
            OFF_IRQ_MASK: begin
                rd_data[FLAG_W-1:0] = irq_mask_q;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    // answer is prepared in the setup cycle, so every access ends in its first access cycle, with no wait states
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            prdata_q <= apb_req_in.pwrite ? '0 : rd_data;
            pslverr_q <= !is_mapped(apb_req_in.paddr);
        end
    end

    assign pready_out = access_phase;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
endmodule
`default_nettype wire

// ===== verification/dso_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// controller side: latches the output lines once per clock
module dso_ctrl_model #(
    parameter int unsigned CHANNELS = 5
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [CHANNELS-1:0] lines_in,
    output logic [CHANNELS-1:0] seen_out
);
    logic [CHANNELS-1:0] seen_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_q <= '0;
        end else begin
            seen_q <= lines_in;
        end
    end
    assign seen_out = seen_q;
endmodule
`default_nettype wire

// ===== verification/dso_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module dso_top_props
    import dso_pkg::*;
#(
    parameter int unsigned CHANNELS = 5
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire dso_pkg::dso_apb_req_t apb_req_in,
    input wire logic pready_out,
    input wire logic [dso_pkg::DATA_W-1:0] prdata_out,
    input wire logic pslverr_out,
    input wire dso_pkg::dso_drive_t drive_in,
    input wire logic drive_ready_out,
    input wire logic control_power_on_out,
    input wire logic zero_speed_out,
    input wire logic target_speed_out,
    input wire logic in_position_out,
    input wire logic [CHANNELS-1:0] do_channel_out,
    input wire logic irq_out
);
    // checks wake one edge after reset release, once the flops have loaded
    logic live_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in || !live_q);

    property p_alarm_blocks;
        drive_in.alarm_pending |=> !drive_ready_out;
    endproperty
    a_alarm_blocks: assert property (p_alarm_blocks) else $error("ready with alarm");
    property p_ready_rises;
        (drive_in.control_power && drive_in.run_capable && !drive_in.alarm_pending) [*2]
            |-> drive_ready_out;
    endproperty
    a_ready_rises: assert property (p_ready_rises) else $error("ready missing");
    property p_power_with_alarm;
        drive_in.control_power && drive_in.alarm_pending |=> control_power_on_out;
    endproperty
    a_power_with_alarm: assert property (p_power_with_alarm) else $error("power flag lost");
    property p_power_drop;
        !drive_in.control_power |=> !control_power_on_out && !drive_ready_out;
    endproperty
    a_power_drop: assert property (p_power_drop) else $error("power flag stuck");
    property p_zero_at_rest;
        drive_in.speed_rpm == 16'h0000 |=> zero_speed_out;
    endproperty
    a_zero_at_rest: assert property (p_zero_at_rest) else $error("zero speed missing");
    property p_channel_source;
        (|do_channel_out) |-> (drive_ready_out || control_power_on_out || zero_speed_out ||
            target_speed_out || in_position_out);
    endproperty
    a_channel_source: assert property (p_channel_source) else $error("channel w/o flag");
    property p_reset_quiet;
        disable iff (1'b0)
        !rst_n_in |-> !(drive_ready_out || control_power_on_out || zero_speed_out ||
            target_speed_out || in_position_out || irq_out || (|do_channel_out));
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output in reset");
    property p_bus_answer;
        apb_req_in.psel && apb_req_in.penable |-> pready_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("no pready");

    c_ready_up: cover property ($rose(drive_ready_out));
    c_irq_up: cover property ($rose(irq_out));
    c_slverr: cover property (pready_out && pslverr_out);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dso_pkg::*;
    localparam int unsigned CHANNELS = 5;
    typedef struct packed {
        logic [2:0] pra;
        logic [15:0] spd;
        logic [31:0] perr;
        logic [10:0] exp;
    } dso_row_t;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b1;
    dso_apb_req_t req = '0;
    dso_drive_t drv = '0;
    logic pready, pslverr, irq, rerr;
    logic [31:0] prdata, rdata;
    logic [4:0] flags;
    logic [CHANNELS-1:0] chan, seen;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    dso_row_t rows [5] = '{
        '{3'h6, 16'h0000, 32'h0000_0000, 11'h3ab},
        '{3'h7, 16'h000a, 32'h0000_0063, 11'h1aa},
        '{3'h4, 16'h000b, 32'h0000_0064, 11'h100},
        '{3'h2, 16'hfff6, 32'hffff_ff9d, 11'h0aa},
        '{3'h6, 16'h01f4, 32'hffff_ff9c, 11'h301}};

    dso_top #(.CHANNELS(CHANNELS)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .apb_req_in(req), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .drive_in(drv), .drive_ready_out(flags[4]), .control_power_on_out(flags[3]),
        .zero_speed_out(flags[2]), .target_speed_out(flags[1]), .in_position_out(flags[0]),
        .do_channel_out(chan), .irq_out(irq));
    dso_ctrl_model #(.CHANNELS(CHANNELS)) u_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .lines_in(chan), .seen_out(seen));

    always #4 clk_in = ~clk_in;

    task automatic finish_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: pins %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: register %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        req.penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_reg(rdata, exp);
    endtask

    // drive state is held, then pins and the controller's view are compared
    task automatic apply(input logic [2:0] pra, input logic [15:0] spd, input logic [31:0] perr,
        input logic [31:0] mp, input logic [31:0] tp, input logic [10:0] exp);
        @(posedge clk_in);
        drv <= {pra, spd, perr, mp, tp};
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk_out({irq, flags, seen}, exp);
    endtask

    initial begin
        rst_n_in <= 1'b0;
        drv.control_power <= 1'b1;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk_out({irq, flags, seen}, 11'h000);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(OFF_ZERO_THR, 32'h0000_000a);
        rd(OFF_POS_WIN, 32'h0000_0063);
        rd(OFF_TARGET_SPD, 32'h0000_0064);
        rd(OFF_DO_MAP, 32'h0000_0a19);
        rd(OFF_IRQ_MASK, 32'h0000_0000);
        rd(OFF_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_reg({31'h0000_0000, rerr}, 32'h0000_0001);
        foreach (rows[i]) begin
            apply(rows[i].pra, rows[i].spd, rows[i].perr, 0, 0, rows[i].exp);
        end
        wr(OFF_ZERO_THR, 32'h0000_0014);
        apply(3'h6, 16'h0014, 0, 0, 0, 11'h3ab);
        apply(3'h6, 16'h0015, 0, 0, 0, 11'h329);
        wr(OFF_CTRL, 32'h0000_0102);
        rd(OFF_ZERO_THR, 32'h0000_000a);
        rd(OFF_DO_MAP, 32'h0000_0119);
        wr(OFF_TARGET_SPD, 32'h0000_0032);
        apply(3'h6, 16'h0031, 0, 0, 0, 11'h301);
        apply(3'h6, 16'h0032, 0, 0, 0, 11'h345);
        apply(3'h6, 16'hffc4, 0, 0, 0, 11'h345);
        wr(OFF_CTRL, 32'h0000_0000);
        apply(3'h6, 16'h003c, 0, 0, 0, 11'h321);
        wr(OFF_CTRL, 32'h0000_0001);
        apply(3'h6, 16'h003c, 32'h0000_1388, 32'h0000_03e8, 32'h0000_044b, 11'h321);
        apply(3'h6, 16'h003c, 32'h0000_1388, 32'h0000_03e8, 32'h0000_044c, 11'h301);
        apply(3'h6, 16'h003c, 32'h0000_1388, 32'h0000_03e8, 32'h0000_0385, 11'h321);
        wr(OFF_DO_MAP, 32'h0000_102a);
        apply(3'h7, 16'h003c, 0, 0, 0, 11'h123);
        apply(3'h6, 16'h003c, 0, 0, 0, 11'h333);
        rd(OFF_FLAGS, 32'h0000_1319);
        rd(OFF_DO_MAP, 32'h0000_102a);
        wr(OFF_IRQ_STATUS, 32'h0000_001f);
        wr(OFF_IRQ_MASK, 32'h0000_0004);
        apply(3'h6, 16'h0000, 0, 0, 0, 11'h7b3);
        rd(OFF_IRQ_STATUS, 32'h0000_0004);
        wr(OFF_IRQ_STATUS, 32'h0000_0004);
        apply(3'h6, 16'h0000, 0, 0, 0, 11'h3b3);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        apply(3'h6, 16'h003c, 0, 0, 0, 11'h333);
        apply(3'h6, 16'h0000, 0, 0, 0, 11'h3b3);
        rd(OFF_IRQ_STATUS, 32'h0000_0004);
        // illegal codes are ignored; ext pulse speed mode uses error window and target speed
        wr(OFF_CTRL, 32'h0000_000f);
        rd(OFF_CTRL, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0004);
        apply(3'h6, 16'h003c, 32'h0000_0064, 0, 0, 11'h351);
        apply(3'h6, 16'h003c, 32'h0000_0063, 0, 0, 11'h373);
        wr(OFF_DO_MAP, 32'h0000_0007);
        wr(OFF_FLAGS, 32'hffff_ffff);
        chk_reg({31'h0000_0000, rerr}, 32'h0000_0000);
        rd(OFF_DO_MAP, 32'h0000_0002);
        rd(OFF_FLAGS, 32'h0000_011b);
        // reset in mid-run restores defaults and quiets every output
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(negedge clk_in);
        chk_out({irq, flags, seen}, 11'h000);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(OFF_CTRL, 32'h0000_0000);
        rd(OFF_DO_MAP, 32'h0000_0a19);
        apply(3'h6, 16'h0000, 0, 0, 0, 11'h3ab);
        finish_test();
    end
endmodule

bind dso_top dso_top_props #(.CHANNELS(CHANNELS)) u_props (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .apb_req_in(apb_req_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out), .drive_in(drive_in),
    .drive_ready_out(drive_ready_out), .control_power_on_out(control_power_on_out),
    .zero_speed_out(zero_speed_out), .target_speed_out(target_speed_out),
    .in_position_out(in_position_out), .do_channel_out(do_channel_out), .irq_out(irq_out));
`default_nettype wire
